// file: verilog/udc_cfg.svh
// Purpose: Register offsets, reset values and count limits of the up/down counter
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Field layouts live in the package as packed structs
`ifndef UDC_CFG_SVH
`define UDC_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define UDC_OFF_CTRL 32'h0000_0000
`define UDC_OFF_STAT 32'h0000_0004

// ----------------------------------------
// Reset values
// ----------------------------------------
`define UDC_CTRL_RST 8'h00
`define UDC_COUNT_RST 4'h0

// ----------------------------------------
// Count limits and step
// ----------------------------------------
`define UDC_MAX 4'hf
`define UDC_MIN 4'h0
`define UDC_ONE 4'h1

// ----------------------------------------
// Read padding
// ----------------------------------------
`define UDC_CTRL_PAD 24'h00_0000
`define UDC_STAT_PAD 25'h000_0000
`define UDC_RD_ZERO 32'h0000_0000

`endif

// file: verilog/udc_pkg.sv
// Purpose: Types shared by the up/down counter
// Assumes: Nothing beyond SystemVerilog packages
// Notes: Struct layouts are the register bit layouts, lsb last
package udc_pkg;

	// ----------------------------------------
	// Control register, byte lane 0
	// ----------------------------------------
	typedef struct packed {
		logic [3:0] preset;
		logic load;
		logic down;
		logic enable;
		logic sw_mode;
	} udc_ctrl_t;

	// ----------------------------------------
	// Status register
	// ----------------------------------------
	typedef struct packed {
		logic direction_down;
		logic ripple_n;
		logic terminal;
		logic [3:0] count;
	} udc_status_t;

endpackage

// file: verilog/udc_counter.sv
// Purpose: Synchronous 4-bit up/down counter with preset and cascade outputs
// Assumes: All pins but arst_n synchronous to clock; count_clk is sampled, not a clock
// Notes: Software may take over the control pins through the control register
//
// How it works
// - Four count bits update together, no ripple
// - Count only on rising edge, enable low
// - Enable high holds the count
// - Direction low counts up, high down
// - Enable and direction changes act only at edges
// - Load low forces count to preset
// - Preset ignores counting clock entirely
// - Count wraps modulo sixteen both ways
// - Terminal high at 15 up, 0 down
// - Ripple low at terminal, clock low and enable low only
`timescale 1ns/1ps
`include "udc_cfg.svh"

module udc_counter import udc_pkg::*; (
	// System
	input wire logic clock,
	input wire logic arst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Counter pins
	input wire logic count_clk,
	input wire logic count_enable_n,
	input wire logic count_down,
	input wire logic load_n,
	input wire logic [3:0] preset_data,
	output logic [3:0] count_out,
	output logic terminal_count,
	output logic ripple_clock_out_n
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [3:0] next_count(input logic [3:0] c, input logic down);
		next_count = down ? c - `UDC_ONE : c + `UDC_ONE;
	endfunction

	function automatic logic at_terminal(input logic [3:0] c, input logic down);
		at_terminal = down ? (c == `UDC_MIN) : (c == `UDC_MAX);
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	udc_ctrl_t ctrl_q;
	logic [3:0] count_q;
	logic [3:0] count_d;
	logic clk_prev_q;
	logic [31:0] rdata_q;

	// ----------------------------------------
	// Control source selection
	// ----------------------------------------
	wire logic eff_enable_n = ctrl_q.sw_mode ? ~ctrl_q.enable : count_enable_n;
	wire logic eff_down = ctrl_q.sw_mode ? ctrl_q.down : count_down;
	wire logic eff_load_n = ctrl_q.sw_mode ? ~ctrl_q.load : load_n;
	wire logic [3:0] eff_preset = ctrl_q.sw_mode ? ctrl_q.preset : preset_data;

	// Rising edge of the sampled counting clock
	wire logic clk_rise = count_clk & ~clk_prev_q;
	wire logic step = clk_rise & ~eff_enable_n;

	// ----------------------------------------
	// Count path
	// ----------------------------------------
	// Load wins over a coincident counting edge, as an asynchronous preset would
	assign count_d = !eff_load_n ? eff_preset :
		step ? next_count(count_q, eff_down) : count_q;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			count_q <= `UDC_COUNT_RST;
			clk_prev_q <= 1'b0;
		end else begin
			count_q <= count_d;
			clk_prev_q <= count_clk;
		end
	end

	// ----------------------------------------
	// Cascade outputs
	// ----------------------------------------
	assign count_out = count_q;
	assign terminal_count = at_terminal(count_q, eff_down);
	// Feeds the next stage's enable or clock; idle high in the clock high phase
	assign ripple_clock_out_n = ~(terminal_count & ~eff_enable_n & ~count_clk);

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	wire logic hit_ctrl = (paddr == `UDC_OFF_CTRL);
	wire logic hit_stat = (paddr == `UDC_OFF_STAT);
	wire logic setup = psel & ~penable;
	wire logic access = psel & penable;
	wire logic ctrl_wr = access & pwrite & hit_ctrl & pstrb[0];
	wire udc_status_t status = '{direction_down: eff_down, ripple_n: ripple_clock_out_n,
		terminal: terminal_count, count: count_q};
	wire logic [31:0] rd_word = hit_ctrl ? {`UDC_CTRL_PAD, ctrl_q} :
		hit_stat ? {`UDC_STAT_PAD, status} : `UDC_RD_ZERO;

	assign pready = 1'b1;
	assign pslverr = access & ~(hit_ctrl | (hit_stat & ~pwrite));
	assign prdata = rdata_q;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= `UDC_CTRL_RST;
			rdata_q <= `UDC_RD_ZERO;
		end else begin
			if (ctrl_wr) begin
				ctrl_q <= pwdata[7:0];
			end
			if (setup) begin
				rdata_q <= pwrite ? `UDC_RD_ZERO : rd_word;
			end
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	sequence s_count_up_from(logic [3:0] v);
		eff_load_n && step && !eff_down && count_q == v;
	endsequence

	sequence s_count_down_from(logic [3:0] v);
		eff_load_n && step && eff_down && count_q == v;
	endsequence

	a_load_preset: assert property (!eff_load_n |=> count_q == $past(eff_preset))
		else $error("count did not take preset during load");
	a_load_no_edge: assert property (!eff_load_n && !clk_rise |=> count_q == $past(eff_preset))
		else $error("preset waited for a counting edge");
	a_inhibit_hold: assert property (eff_load_n && eff_enable_n |=> $stable(count_q))
		else $error("count moved while inhibited");
	a_edge_only: assert property (eff_load_n && !clk_rise |=> $stable(count_q))
		else $error("count moved without a rising edge");
	a_ctrl_change_hold: assert property (eff_load_n && !step && $changed(eff_down)
		|=> $stable(count_q))
		else $error("direction change altered count");
	a_count_up: assert property (eff_load_n && step && !eff_down
		|=> count_q == $past(count_q) + `UDC_ONE)
		else $error("up count wrong");
	a_count_down: assert property (eff_load_n && step && eff_down
		|=> count_q == $past(count_q) - `UDC_ONE)
		else $error("down count wrong");
	a_wrap_up: assert property (s_count_up_from(`UDC_MAX) |=> count_q == `UDC_MIN)
		else $error("no wrap from 15 to 0");
	a_wrap_down: assert property (s_count_down_from(`UDC_MIN) |=> count_q == `UDC_MAX)
		else $error("no wrap from 0 to 15");
	a_bits_together: assert property ($changed(count_out)
		|-> $past(step) || !$past(eff_load_n))
		else $error("count changed without cause");
	a_terminal_max: assert property (s_count_up_from(`UDC_MAX - `UDC_ONE) ##1 !eff_down
		|-> terminal_count)
		else $error("terminal missing at 15 counting up");
	a_terminal_min: assert property (s_count_down_from(`UDC_ONE) ##1 eff_down
		|-> terminal_count)
		else $error("terminal missing at 0 counting down");
	a_ripple_low: assert property (terminal_count && !eff_enable_n && !count_clk
		|-> !ripple_clock_out_n)
		else $error("ripple not low in clock low phase");
	a_ripple_phase: assert property (count_clk |-> ripple_clock_out_n)
		else $error("ripple low in clock high phase");
	a_ripple_inhibit: assert property (eff_enable_n |-> ripple_clock_out_n)
		else $error("ripple asserted by inhibited stage");
	a_apb_ctrl_write: assert property (ctrl_wr |=> ctrl_q == $past(pwdata[7:0]))
		else $error("control write lost");
	a_apb_unmapped: assert property (access && !hit_ctrl && !hit_stat |-> pslverr)
		else $error("unmapped access not flagged");

endmodule

// file: sim/udc_cascade_stage.sv
// Purpose: Next counter stage fed by the ripple output, clocks shared
// Assumes: Samples the counting clock on the system clock like the block does
// Notes: Counts carries only; used to judge cascading
`timescale 1ns/1ps
module udc_cascade_stage (
	// System
	input wire logic clock,
	input wire logic arst_n,
	// Shared counting clock and carry in
	input wire logic count_clk,
	input wire logic count_enable_n,
	// Look-ahead carry built from the terminal output
	input wire logic look_ahead,
	// Next-stage counts
	output logic [3:0] count_q,
	output logic [3:0] look_count
);
	logic clk_q;
	logic en_n_q;
	logic la_q;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			clk_q <= 1'b0;
			en_n_q <= 1'b1;
			la_q <= 1'b0;
			count_q <= 4'h0;
			look_count <= 4'h0;
		end else begin
			clk_q <= count_clk;
			en_n_q <= count_enable_n;
			la_q <= look_ahead;
			if (count_clk && !clk_q && !en_n_q) begin
				count_q <= count_q + 4'h1;
			end
			if (count_clk && !clk_q && la_q) begin
				look_count <= look_count + 4'h1;
			end
		end
	end
endmodule

// file: sim/tb_up_down_binary_counter_4bit.sv
// Purpose: Self-checking bench of the up/down counter
// Assumes: APB slave answers when ready, count_clk sampled by clock
// Notes: Second stage model watches the ripple and terminal outputs
`timescale 1ns/1ps
`include "udc_cfg.svh"
module tb_up_down_binary_counter_4bit import udc_pkg::*;;
	logic clock = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
	logic count_clk = 0, count_enable_n = 1, count_down = 0, load_n = 1;
	logic terminal_count, ripple_clock_out_n;
	logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
	logic [3:0] pstrb = 4'hf, preset_data = 4'h0, count_out, next_count, look_count;
	int num_errors = 0, tests_run = 0, cyc = 0;
	udc_counter i_udc_counter (.clock(clock), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .count_clk(count_clk),
		.count_enable_n(count_enable_n), .count_down(count_down), .load_n(load_n),
		.preset_data(preset_data), .count_out(count_out), .terminal_count(terminal_count),
		.ripple_clock_out_n(ripple_clock_out_n));
	udc_cascade_stage i_udc_cascade_stage (.clock(clock), .arst_n(arst_n),
		.count_clk(count_clk), .count_enable_n(ripple_clock_out_n),
		.look_ahead(terminal_count & ~count_enable_n), .count_q(next_count),
		.look_count(look_count));
	always #2.5 clock = ~clock;
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// One counting clock pulse, returns in its low phase with outputs settled
	task automatic step();
		@(posedge clock);
		count_clk <= 1;
		repeat (2) @(posedge clock);
		count_clk <= 0;
		repeat (2) @(posedge clock);
		@(negedge clock);
	endtask
	task automatic t_regs();
		apb(0, `UDC_OFF_CTRL, 0);
		chk("ctrl reset", 32'h0000_0000, rd);
		apb(0, `UDC_OFF_STAT, 0);
		chk("stat reset", 32'h0000_0020, rd);
		apb(0, 32'h0000_0008, 0);
		chk("unmapped err", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		apb(1, `UDC_OFF_STAT, 32'hff);
		chk("stat write err", 32'h1, {31'h0, er});
		pstrb <= 4'he;
		apb(1, `UDC_OFF_CTRL, 32'h0000_0001);
		pstrb <= 4'hf;
		apb(0, `UDC_OFF_CTRL, 0);
		chk("ctrl strobe off", 32'h0, rd);
		chk("ctrl strobe err", 32'h0, {31'h0, er});
		$display("registers done");
	endtask
	task automatic t_load_up();
		@(posedge clock);
		load_n <= 0;
		preset_data <= 4'hd;
		count_clk <= 1;
		repeat (2) @(posedge clock);
		@(negedge clock);
		chk("load", 32'hd, count_out);
		@(posedge clock);
		load_n <= 1;
		count_clk <= 0;
		count_enable_n <= 0;
		step();
		chk("up 14", 32'he, count_out);
		step();
		chk("up 15", 32'hf, count_out);
		chk("terminal up", 32'h1, terminal_count);
		chk("ripple low", 32'h0, ripple_clock_out_n);
		@(posedge clock);
		count_clk <= 1;
		@(negedge clock);
		chk("ripple high phase", 32'h1, ripple_clock_out_n);
		@(posedge clock);
		count_clk <= 0;
		repeat (2) @(posedge clock);
		@(negedge clock);
		chk("wrap up", 32'h0, count_out);
		chk("next stage", 32'h1, next_count);
		chk("look ahead", 32'h1, look_count);
		$display("load and count up done");
	endtask
	task automatic t_inhibit_down();
		@(posedge clock);
		count_enable_n <= 1;
		count_down <= 1;
		repeat (2) @(posedge clock);
		@(negedge clock);
		chk("dir change no edge", 32'h0, count_out);
		chk("terminal down", 32'h1, terminal_count);
		step();
		chk("inhibit", 32'h0, count_out);
		chk("ripple inhibited", 32'h1, ripple_clock_out_n);
		@(posedge clock);
		count_enable_n <= 0;
		step();
		chk("wrap down", 32'hf, count_out);
		chk("next stage borrow", 32'h2, next_count);
		chk("look ahead borrow", 32'h2, look_count);
		step();
		chk("down 14", 32'he, count_out);
		$display("inhibit and count down done");
	endtask
	task automatic t_soft();
		@(posedge clock);
		count_enable_n <= 1;
		apb(1, `UDC_OFF_CTRL, 32'h0000_009b);
		repeat (2) @(posedge clock);
		@(negedge clock);
		chk("soft load", 32'h9, count_out);
		apb(0, `UDC_OFF_STAT, 0);
		chk("stat count", 32'h0000_0029, rd);
		apb(1, `UDC_OFF_CTRL, 32'h0000_0007);
		step();
		chk("soft down", 32'h8, count_out);
		apb(0, `UDC_OFF_STAT, 0);
		chk("stat down", 32'h0000_0068, rd);
		apb(1, `UDC_OFF_CTRL, 32'h0);
		$display("software control done");
	endtask
	initial begin
		repeat (2) @(posedge clock);
		arst_n <= 1;
		t_regs();
		t_load_up();
		t_inhibit_down();
		t_soft();
		complete_run();
	end
endmodule
